// ==== mad_datapath.sv ====
// Execution datapath for moves, arithmetic, logic and process operations.
// Assumes RAM and ROM return read data one clock after the read strobe.
// Notes on behaviour
// - Literal-to-memory move only writes addresses 0x80 to 0x87.
// - Bank-0 exchange swaps accumulator and memory, one cycle plus N.
// - Table lookup loads ROM word at Y,Z into R and A, two cycles.
// - Add with carry sums A, operand and C; C is the carry out.
// - Bank-0 add writes memory plus A back, updates C, one plus N.
// - Add literal to A in one cycle, C set on carry out.
// - Subtract with borrow: A minus operand minus not C; C low on borrow.
// - Subtract literal from A in one cycle, C cleared on borrow.
// - AND to memory writes back, touches only Z, one plus N cycles.
// - AND literal with A in one cycle, only Z affected.
// - XOR literal with A in one cycle, only Z affected.
// - Nibble swap loads A with swapped operand, flags unchanged.
// - Rotates go through C; memory form costs one plus N cycles.
// - Extra cycle N is one for RAM, zero for system registers.
`timescale 1ns/100ps
`default_nettype none
`include "mad_consts.svh"
module mad_datapath (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Decoder side
	input wire logic op_valid,
	input wire mad_pkg::mad_op_t op_code,
	input wire logic op_bank0,
	input wire logic [7:0] op_addr,
	input wire logic [7:0] op_imm,
	input wire logic [7:0] idx_y,
	input wire logic [7:0] idx_z,
	output logic op_ready,
	output logic op_done,
	output logic op_illegal,
	// Data RAM and system registers
	output logic [7:0] mem_addr,
	output logic mem_bank0,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	// Program ROM
	output logic [15:0] rom_addr,
	output logic rom_rd,
	input wire logic [15:0] rom_rdata,
	// Architectural state
	output logic [7:0] acc,
	output logic [7:0] r_reg,
	output logic flag_c,
	output logic flag_dc,
	output logic flag_z
);
	import mad_pkg::*;

	////////////////////////////////////////////////////////////////////
	function automatic mad_fn_t fn_of(input mad_op_t op);
		unique case (op)
			MAD_ADC_AM, MAD_ADC_MA: fn_of = MAD_FN_ADC;
			MAD_ADD_AM, MAD_ADD_MA, MAD_ADD_AI: fn_of = MAD_FN_ADD;
			MAD_SBC_AM, MAD_SBC_MA: fn_of = MAD_FN_SBC;
			MAD_SUB_AM, MAD_SUB_MA, MAD_SUB_AI: fn_of = MAD_FN_SUB;
			MAD_AND_AM, MAD_AND_MA, MAD_AND_AI: fn_of = MAD_FN_AND;
			MAD_OR_AM, MAD_OR_MA, MAD_OR_AI: fn_of = MAD_FN_OR;
			MAD_XOR_AM, MAD_XOR_MA, MAD_XOR_AI: fn_of = MAD_FN_XOR;
			MAD_MOV_MA: fn_of = MAD_FN_PASSA;
			MAD_SWAP, MAD_NIBBLE_SWAP_IN_PLACE: fn_of = MAD_FN_SWAP;
			MAD_RRC, MAD_ROTATE_RIGHT_CARRY_MEMORY: fn_of = MAD_FN_RRC;
			MAD_RLC, MAD_ROTATE_LEFT_CARRY_MEMORY: fn_of = MAD_FN_RLC;
			MAD_CLR: fn_of = MAD_FN_ZERO;
			default: fn_of = MAD_FN_PASSB;
		endcase
	endfunction : fn_of

	function automatic logic dest_mem(input mad_op_t op);
		dest_mem = op inside {MAD_MOV_MA, MAD_MOV_MI, MAD_XCH, MAD_ADC_MA,
			MAD_ADD_MA, MAD_SBC_MA, MAD_SUB_MA, MAD_AND_MA, MAD_OR_MA,
			MAD_XOR_MA, MAD_NIBBLE_SWAP_IN_PLACE, MAD_ROTATE_RIGHT_CARRY_MEMORY, MAD_ROTATE_LEFT_CARRY_MEMORY, MAD_CLR};
	endfunction : dest_mem

	function automatic logic uses_imm(input mad_op_t op);
		uses_imm = op inside {MAD_MOV_AI, MAD_MOV_MI, MAD_ADD_AI,
			MAD_SUB_AI, MAD_AND_AI, MAD_OR_AI, MAD_XOR_AI};
	endfunction : uses_imm

	// Plain stores and clear are one cycle whatever the target
	function automatic logic pays_n(input mad_op_t op, input logic [7:0] a);
		pays_n = dest_mem(op) && !(op inside {MAD_MOV_MA, MAD_MOV_MI,
			MAD_CLR}) && !a[`MAD_SYSREG_BIT];
	endfunction : pays_n

	function automatic logic imm_bad(input mad_op_t op, input logic [7:0] a);
		imm_bad = op == MAD_MOV_MI && (a < `MAD_IMM_LO || a > `MAD_IMM_HI);
	endfunction : imm_bad

	////////////////////////////////////////////////////////////////////
	logic rst_meta_q;
	logic rst_q;
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			rst_meta_q <= 1'b0;
			rst_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_q <= rst_meta_q;
		end

	mad_st_t st_q;
	mad_op_t op_q;
	logic [7:0] addr_q;
	logic [7:0] imm_q;
	logic ready_q, done_q, illegal_q, bank0_q, rd_q, wr_q, rom_rd_q;
	logic [7:0] wdata_q, acc_q, r_q;
	logic [15:0] rom_addr_q;
	logic c_q, dc_q, z_q;
	logic accept;
	logic pen;
	mad_alu_if alu_bus ();

	assign accept = op_valid && ready_q;
	assign pen = op_q == MAD_ROM_TABLE_LOOKUP || pays_n(op_q, addr_q);

	assign alu_bus.fn = fn_of(op_q);
	assign alu_bus.a = acc_q;
	assign alu_bus.b = uses_imm(op_q) ? imm_q : mem_rdata;
	assign alu_bus.cin = c_q;

	mad_alu u_alu (
		.bus(alu_bus)
	);

	////////////////////////////////////////////////////////////////////
	// Sequencer: fetch, execute, optional penalty cycle
	always_ff @(posedge clk or negedge rst_q)
		if (!rst_q)
		begin
			st_q <= MAD_ST_IDLE;
			ready_q <= 1'b1;
			done_q <= 1'b0;
			illegal_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			illegal_q <= 1'b0;
			unique case (st_q)
				MAD_ST_IDLE:
					if (accept)
					begin
						st_q <= MAD_ST_FETCH;
						ready_q <= 1'b0;
					end
				MAD_ST_FETCH: st_q <= MAD_ST_EXEC;
				MAD_ST_EXEC:
					if (pen)
						st_q <= MAD_ST_PEN;
					else
					begin
						st_q <= MAD_ST_IDLE;
						ready_q <= 1'b1;
						done_q <= 1'b1;
						illegal_q <= imm_bad(op_q, addr_q);
					end
				MAD_ST_PEN:
				begin
					st_q <= MAD_ST_IDLE;
					ready_q <= 1'b1;
					done_q <= 1'b1;
				end
			endcase
		end

	// Operand capture and bus strobes
	always_ff @(posedge clk or negedge rst_q)
		if (!rst_q)
		begin
			op_q <= MAD_MOV_AM;
			addr_q <= `MAD_BYTE_ZERO;
			imm_q <= `MAD_BYTE_ZERO;
			bank0_q <= 1'b0;
			rd_q <= 1'b0;
			rom_rd_q <= 1'b0;
			rom_addr_q <= 16'h0000;
			wr_q <= 1'b0;
			wdata_q <= `MAD_BYTE_ZERO;
		end
		else
		begin
			rd_q <= 1'b0;
			rom_rd_q <= 1'b0;
			wr_q <= 1'b0;
			if (accept)
			begin
				op_q <= op_code;
				addr_q <= op_addr;
				imm_q <= op_imm;
				bank0_q <= op_bank0;
				rd_q <= !uses_imm(op_code) && op_code != MAD_ROM_TABLE_LOOKUP
					&& op_code != MAD_MOV_MA && op_code != MAD_CLR;
				rom_rd_q <= op_code == MAD_ROM_TABLE_LOOKUP;
				rom_addr_q <= {idx_y, idx_z};
			end
			if (st_q == MAD_ST_EXEC)
			begin
				// A rejected literal store never reaches the bus
				wr_q <= dest_mem(op_q) && !imm_bad(op_q, addr_q);
				wdata_q <= op_q == MAD_XCH ? acc_q : alu_bus.res;
			end
		end

	// Accumulator, R and flags change only in the execute cycle
	always_ff @(posedge clk or negedge rst_q)
		if (!rst_q)
		begin
			acc_q <= `MAD_BYTE_ZERO;
			r_q <= `MAD_BYTE_ZERO;
			c_q <= 1'b0;
			dc_q <= 1'b0;
			z_q <= 1'b0;
		end
		else if (st_q == MAD_ST_EXEC)
		begin
			if (op_q == MAD_ROM_TABLE_LOOKUP)
			begin
				acc_q <= rom_rdata[`MAD_ROM_LO];
				r_q <= rom_rdata[`MAD_ROM_HI];
			end
			else if (op_q == MAD_XCH)
				acc_q <= mem_rdata;
			else if (!dest_mem(op_q))
				acc_q <= alu_bus.res;
			unique case (fn_of(op_q))
				MAD_FN_ADD, MAD_FN_ADC, MAD_FN_SUB, MAD_FN_SBC:
				begin
					c_q <= alu_bus.cout;
					dc_q <= alu_bus.dcout;
					z_q <= alu_bus.res == `MAD_BYTE_ZERO;
				end
				MAD_FN_AND, MAD_FN_OR, MAD_FN_XOR:
					z_q <= alu_bus.res == `MAD_BYTE_ZERO;
				MAD_FN_RRC, MAD_FN_RLC: c_q <= alu_bus.cout;
				default:
				begin
				end
			endcase
		end

	assign op_ready = ready_q;
	assign op_done = done_q;
	assign op_illegal = illegal_q;
	assign mem_addr = addr_q;
	assign mem_bank0 = bank0_q;
	assign mem_rd = rd_q;
	assign mem_wr = wr_q;
	assign mem_wdata = wdata_q;
	assign rom_addr = rom_addr_q;
	assign rom_rd = rom_rd_q;
	assign acc = acc_q;
	assign r_reg = r_q;
	assign flag_c = c_q;
	assign flag_dc = dc_q;
	assign flag_z = z_q;

	////////////////////////////////////////////////////////////////////
	imm_range_a: assert property (@(posedge clk) disable iff (!rst_q)
		accept && imm_bad(op_code, op_addr) |-> ##3 op_illegal && !mem_wr)
		else $error("literal store outside range not refused");
	xch_swap_a: assert property (@(posedge clk) disable iff (!rst_q)
		accept && op_code == MAD_XCH |-> ##3 mem_wr
		&& mem_wdata == $past(acc, 3) && acc == $past(mem_rdata))
		else $error("exchange did not swap");
	table_load_a: assert property (@(posedge clk) disable iff (!rst_q)
		accept && op_code == MAD_ROM_TABLE_LOOKUP |-> ##1 rom_rd ##2
		acc == $past(rom_rdata[`MAD_ROM_LO]) && !op_done ##1 op_done)
		else $error("table lookup wrong data or timing");
	adc_sum_a: assert property (@(posedge clk) disable iff (!rst_q)
		st_q == MAD_ST_EXEC && op_q == MAD_ADC_AM |=> {flag_c, acc}
		== {1'b0, $past(acc)} + {1'b0, $past(mem_rdata)} + {8'h00, $past(c_q)})
		else $error("add with carry result wrong");
	sbc_borrow_a: assert property (@(posedge clk) disable iff (!rst_q)
		st_q == MAD_ST_EXEC && op_q == MAD_SBC_AM |=> {flag_c, acc}
		== {1'b0, $past(acc)} + {1'b0, ~$past(mem_rdata)} + {8'h00, $past(c_q)})
		else $error("subtract with borrow result wrong");
	logic_flags_a: assert property (@(posedge clk) disable iff (!rst_q)
		st_q == MAD_ST_EXEC && op_q == MAD_AND_AI |=> $stable(flag_c)
		&& $stable(flag_dc) && flag_z == (acc == 8'h00))
		else $error("logic op disturbed carry flags");
	swap_nib_a: assert property (@(posedge clk) disable iff (!rst_q)
		st_q == MAD_ST_EXEC && op_q == MAD_SWAP |=> acc == {$past(mem_rdata[3:0]),
		$past(mem_rdata[7:4])} && $stable({flag_c, flag_dc, flag_z}))
		else $error("nibble swap wrong");
	rotate_carry_a: assert property (@(posedge clk) disable iff (!rst_q)
		st_q == MAD_ST_EXEC && op_q == MAD_RLC |=> {flag_c, acc}
		== {$past(mem_rdata), $past(c_q)})
		else $error("rotate left through carry wrong");
	ram_penalty_a: assert property (@(posedge clk) disable iff (!rst_q)
		accept && pays_n(op_code, op_addr) |-> ##3 !op_done ##1 op_done)
		else $error("RAM operand penalty cycle missing");
	sysreg_nopen_a: assert property (@(posedge clk) disable iff (!rst_q)
		accept && dest_mem(op_code) && op_addr[`MAD_SYSREG_BIT] |-> ##3 op_done)
		else $error("system register charged extra cycle");
	clear_zero_a: assert property (@(posedge clk) disable iff (!rst_q)
		accept && op_code == MAD_CLR |-> ##3 op_done && mem_wr
		&& mem_wdata == 8'h00 && $stable({flag_c, flag_dc, flag_z}))
		else $error("clear wrote nonzero or moved flags");
endmodule : mad_datapath
`default_nettype wire

// ==== mad_consts.svh ====
// Constants for the move and arithmetic datapath.
// Assumes inclusion by bare name from every file that needs the numbers.
`ifndef MAD_CONSTS_SVH
`define MAD_CONSTS_SVH
`define MAD_BYTE_ZERO 8'h00
`define MAD_IMM_LO 8'h80
`define MAD_IMM_HI 8'h87
`define MAD_SYSREG_BIT 7
`define MAD_NIB_HI 7:4
`define MAD_NIB_LO 3:0
`define MAD_ROM_HI 15:8
`define MAD_ROM_LO 7:0
`endif

// ==== mad_pkg.sv ====
// Types shared by the datapath and its function unit.
// Assumes the opcode is already decoded by the decoder upstream.
`default_nettype none
package mad_pkg;
	typedef enum logic [4:0] {
		MAD_MOV_AM = 5'h00, MAD_MOV_MA = 5'h01, MAD_MOV_AI = 5'h02,
		MAD_MOV_MI = 5'h03, MAD_XCH = 5'h04, MAD_ROM_TABLE_LOOKUP = 5'h05,
		MAD_ADC_AM = 5'h06, MAD_ADC_MA = 5'h07, MAD_ADD_AM = 5'h08,
		MAD_ADD_MA = 5'h09, MAD_ADD_AI = 5'h0a, MAD_SBC_AM = 5'h0b,
		MAD_SBC_MA = 5'h0c, MAD_SUB_AM = 5'h0d, MAD_SUB_MA = 5'h0e,
		MAD_SUB_AI = 5'h0f, MAD_AND_AM = 5'h10, MAD_AND_MA = 5'h11,
		MAD_AND_AI = 5'h12, MAD_OR_AM = 5'h13, MAD_OR_MA = 5'h14,
		MAD_OR_AI = 5'h15, MAD_XOR_AM = 5'h16, MAD_XOR_MA = 5'h17,
		MAD_XOR_AI = 5'h18, MAD_SWAP = 5'h19, MAD_NIBBLE_SWAP_IN_PLACE = 5'h1a,
		MAD_RRC = 5'h1b, MAD_ROTATE_RIGHT_CARRY_MEMORY = 5'h1c, MAD_RLC = 5'h1d,
		MAD_ROTATE_LEFT_CARRY_MEMORY = 5'h1e, MAD_CLR = 5'h1f
	} mad_op_t;
	typedef enum logic [3:0] {
		MAD_FN_ADD = 4'h0, MAD_FN_ADC = 4'h1, MAD_FN_SUB = 4'h2,
		MAD_FN_SBC = 4'h3, MAD_FN_AND = 4'h4, MAD_FN_OR = 4'h5,
		MAD_FN_XOR = 4'h6, MAD_FN_PASSA = 4'h7, MAD_FN_PASSB = 4'h8,
		MAD_FN_SWAP = 4'h9, MAD_FN_RRC = 4'ha, MAD_FN_RLC = 4'hb,
		MAD_FN_ZERO = 4'hc
	} mad_fn_t;
	typedef enum logic [1:0] {
		MAD_ST_IDLE = 2'b00, MAD_ST_FETCH = 2'b01,
		MAD_ST_EXEC = 2'b10, MAD_ST_PEN = 2'b11
	} mad_st_t;
endpackage : mad_pkg
`default_nettype wire

// ==== mad_alu_if.sv ====
// Function-unit connection between the datapath and its adder/logic unit.
// Assumes a purely combinational unit on the alu side.
`timescale 1ns/100ps
`default_nettype none
interface mad_alu_if;
	import mad_pkg::*;
	mad_fn_t fn;
	logic [7:0] a;
	logic [7:0] b;
	logic cin;
	logic [7:0] res;
	logic cout;
	logic dcout;
	modport alu (input fn, a, b, cin, output res, cout, dcout);
	modport user (output fn, a, b, cin, input res, cout, dcout);
endinterface : mad_alu_if
`default_nettype wire

// ==== mad_alu.sv ====
// Combinational adder, logic and shift unit of the datapath.
// Assumes a is the accumulator and b the memory, literal or rotate operand.
`timescale 1ns/100ps
`default_nettype none
module mad_alu (
	// Function-unit connection
	mad_alu_if.alu bus
);
	import mad_pkg::*;
	logic [7:0] bb;
	logic ci;
	logic [8:0] sum9;
	logic [4:0] sum5;
	always_comb
	begin
		// One adder serves both add and subtract: carry means no borrow
		bb = bus.b;
		ci = 1'b0;
		if (bus.fn == MAD_FN_SUB || bus.fn == MAD_FN_SBC)
			bb = ~bus.b;
		if (bus.fn == MAD_FN_ADC || bus.fn == MAD_FN_SBC)
			ci = bus.cin;
		else if (bus.fn == MAD_FN_SUB)
			ci = 1'b1;
		sum9 = {1'b0, bus.a} + {1'b0, bb} + {8'h00, ci};
		sum5 = {1'b0, bus.a[`MAD_NIB_LO]} + {1'b0, bb[`MAD_NIB_LO]}
			+ {4'h0, ci};
		bus.dcout = sum5[4];
		bus.cout = sum9[8];
		unique case (bus.fn)
			MAD_FN_ADD, MAD_FN_ADC, MAD_FN_SUB, MAD_FN_SBC:
				bus.res = sum9[7:0];
			MAD_FN_AND: bus.res = bus.a & bus.b;
			MAD_FN_OR: bus.res = bus.a | bus.b;
			MAD_FN_XOR: bus.res = bus.a ^ bus.b;
			MAD_FN_PASSA: bus.res = bus.a;
			MAD_FN_PASSB: bus.res = bus.b;
			MAD_FN_SWAP: bus.res = {bus.b[`MAD_NIB_LO], bus.b[`MAD_NIB_HI]};
			MAD_FN_RRC:
			begin
				bus.res = {bus.cin, bus.b[7:1]};
				bus.cout = bus.b[0];
			end
			MAD_FN_RLC:
			begin
				bus.res = {bus.b[6:0], bus.cin};
				bus.cout = bus.b[7];
			end
			MAD_FN_ZERO: bus.res = `MAD_BYTE_ZERO;
			default: bus.res = `MAD_BYTE_ZERO;
		endcase
	end
endmodule : mad_alu
`default_nettype wire

// ==== mad_mem_model.sv ====
// Behavioural data RAM, system registers and program ROM for the datapath.
// Assumes read and write strobes are one-cycle pulses off the rising edge.
`timescale 1ns/100ps
`default_nettype none
module mad_mem_model (
	// Clock
	input wire logic clk,
	// Data RAM and system registers
	input wire logic [7:0] mem_addr,
	input wire logic mem_bank0,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	// Program ROM
	input wire logic [15:0] rom_addr,
	input wire logic rom_rd,
	output logic [15:0] rom_rdata
);
	// One flat space: bank select is not decoded here
	logic [7:0] ram [256];

	////////////////////////////////////////////////////////////////
	initial
	begin
		mem_rdata = 8'h00;
		rom_rdata = 16'h0000;
	end

	// Read data stands one cycle, then turns to its inverse
	always @(posedge clk)
	begin
		if (mem_wr)
			ram[mem_addr] <= mem_wdata;
		if (mem_rd)
			mem_rdata <= ram[mem_addr];
		else
			mem_rdata <= ~mem_rdata;
	end

	// Word content is a fixed scramble of its address
	always @(posedge clk)
	begin
		if (rom_rd)
			rom_rdata <= rom_addr ^ 16'h5ac3;
		else
			rom_rdata <= ~rom_rdata;
	end
endmodule : mad_mem_model
`default_nettype wire

// ==== mad_datapath_test.sv ====
// Self-checking bench for the move and arithmetic datapath.
// Assumes mad_pkg, the datapath sources and mad_mem_model are compiled.
`timescale 1ns/100ps
`default_nettype none
module mad_datapath_test;
	import mad_pkg::*;
	typedef struct {
		mad_op_t op;
		logic [7:0] ad, a0, m0, im;
		logic c0, bk;
		logic [7:0] ea, em;
		logic ec, ez, il;
		int cy;
	} mad_row_t;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic op_valid = 1'h0;
	mad_op_t op_code = MAD_MOV_AM;
	logic op_bank0 = 1'h0;
	logic [7:0] op_addr = 8'h00;
	logic [7:0] op_imm = 8'h00;
	logic [7:0] idx_y = 8'h00;
	logic [7:0] idx_z = 8'h00;
	logic op_ready, op_done, op_illegal, mem_bank0, mem_rd, mem_wr, rom_rd;
	logic [7:0] mem_addr, mem_wdata, mem_rdata, acc, r_reg;
	logic [15:0] rom_addr, rom_rdata;
	logic flag_c, flag_dc, flag_z;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cycles = 0;
	mad_row_t rows [$];

	////////////////////////////////////////////////////////////////
	mad_datapath u_dut (
		.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
		.op_bank0(op_bank0), .op_addr(op_addr), .op_imm(op_imm),
		.idx_y(idx_y), .idx_z(idx_z), .op_ready(op_ready),
		.op_done(op_done), .op_illegal(op_illegal), .mem_addr(mem_addr),
		.mem_bank0(mem_bank0), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .rom_addr(rom_addr),
		.rom_rd(rom_rd), .rom_rdata(rom_rdata), .acc(acc), .r_reg(r_reg),
		.flag_c(flag_c), .flag_dc(flag_dc), .flag_z(flag_z)
	);
	mad_mem_model u_mem (
		.clk(clk), .mem_addr(mem_addr), .mem_bank0(mem_bank0),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .rom_addr(rom_addr), .rom_rd(rom_rd),
		.rom_rdata(rom_rdata)
	);

	initial
	begin
		forever #10 clk = ~clk;
	end

	// Whole run needs roughly seven hundred cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 4000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Offer one instruction, return at the sample of its done cycle
	task automatic do_op(input mad_op_t op, input logic [7:0] a, im,
		input logic b, output int n, output logic il);
		@(posedge clk);
		op_valid <= 1'h1;
		op_code <= op;
		op_addr <= a;
		op_imm <= im;
		op_bank0 <= b;
		@(posedge clk);
		op_valid <= 1'h0;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (op_done !== 1'h1 && n < 20);
		il = op_illegal;
		n = n - 2;
	endtask : do_op

	// Carry, decimal carry and zero all start as c0, c0 and one
	task automatic run_row(input mad_row_t r);
		int n;
		logic il;
		do_op(MAD_MOV_AI, 8'h00, {8{r.c0}}, 1'h0, n, il);
		do_op(MAD_ADD_AI, 8'h00, {7'h00, r.c0}, 1'h0, n, il);
		do_op(MAD_MOV_AI, 8'h00, r.a0, 1'h0, n, il);
		u_mem.ram[r.ad] = r.m0;
		do_op(r.op, r.ad, r.im, r.bk, n, il);
		// A late write strobe may land one edge after done
		@(negedge clk);
		chk(16'(acc), 16'(r.ea));
		chk(16'(u_mem.ram[r.ad]), 16'(r.em));
		chk(16'(flag_c), 16'(r.ec));
		chk(16'(flag_z), 16'(r.ez));
		if (!(r.op inside {[MAD_ADC_AM:MAD_SUB_AI]}))
			chk(16'(flag_dc), 16'(r.c0));
		chk(16'(il), 16'(r.il));
		chk(16'({mem_bank0, mem_addr}), 16'({r.bk, r.ad}));
		chk(16'(n), 16'(r.cy));
	endtask : run_row

	////////////////////////////////////////////////////////////////
	initial
	begin
		int n;
		logic il;
		rows = '{
		'{MAD_MOV_AM,8'h10,8'h00,8'h3c,8'h00,1'h0,1'h0,8'h3c,8'h3c,1'h0,1'h1,1'h0,1},
		'{MAD_MOV_MA,8'h11,8'h5a,8'h00,8'h00,1'h0,1'h0,8'h5a,8'h5a,1'h0,1'h1,1'h0,1},
		'{MAD_MOV_MI,8'h83,8'h00,8'h00,8'h9c,1'h0,1'h0,8'h00,8'h9c,1'h0,1'h1,1'h0,1},
		'{MAD_MOV_MI,8'h87,8'h00,8'h00,8'h9d,1'h1,1'h0,8'h00,8'h9d,1'h1,1'h1,1'h0,1},
		'{MAD_MOV_MI,8'h88,8'h00,8'h11,8'h9c,1'h0,1'h0,8'h00,8'h11,1'h0,1'h1,1'h1,1},
		'{MAD_XCH,8'h12,8'h12,8'h34,8'h00,1'h0,1'h0,8'h34,8'h12,1'h0,1'h1,1'h0,2},
		'{MAD_XCH,8'h85,8'h12,8'h34,8'h00,1'h0,1'h1,8'h34,8'h12,1'h0,1'h1,1'h0,1},
		'{MAD_ADC_AM,8'h10,8'hf0,8'h0f,8'h00,1'h1,1'h0,8'h00,8'h0f,1'h1,1'h1,1'h0,1},
		'{MAD_ADC_MA,8'h10,8'h10,8'h20,8'h00,1'h1,1'h0,8'h10,8'h31,1'h0,1'h0,1'h0,2},
		'{MAD_ADD_MA,8'h13,8'h80,8'h80,8'h00,1'h0,1'h1,8'h80,8'h00,1'h1,1'h1,1'h0,2},
		'{MAD_ADD_MA,8'h84,8'h01,8'h02,8'h00,1'h1,1'h1,8'h01,8'h03,1'h0,1'h0,1'h0,1},
		'{MAD_ADD_AI,8'h20,8'h01,8'h00,8'h7f,1'h1,1'h0,8'h80,8'h00,1'h0,1'h0,1'h0,1},
		'{MAD_ADD_AI,8'h20,8'h01,8'h00,8'hff,1'h0,1'h0,8'h00,8'h00,1'h1,1'h1,1'h0,1},
		'{MAD_SBC_AM,8'h10,8'h05,8'h03,8'h00,1'h0,1'h0,8'h01,8'h03,1'h1,1'h0,1'h0,1},
		'{MAD_SBC_AM,8'h10,8'h03,8'h05,8'h00,1'h1,1'h0,8'hfe,8'h05,1'h0,1'h0,1'h0,1},
		'{MAD_SUB_AI,8'h20,8'h05,8'h00,8'h05,1'h0,1'h0,8'h00,8'h00,1'h1,1'h1,1'h0,1},
		'{MAD_SUB_AI,8'h20,8'h04,8'h00,8'h05,1'h1,1'h0,8'hff,8'h00,1'h0,1'h0,1'h0,1},
		'{MAD_AND_MA,8'h14,8'h3c,8'hf0,8'h00,1'h1,1'h0,8'h3c,8'h30,1'h1,1'h0,1'h0,2},
		'{MAD_AND_AI,8'h20,8'h3c,8'h00,8'h0f,1'h0,1'h0,8'h0c,8'h00,1'h0,1'h0,1'h0,1},
		'{MAD_XOR_AI,8'h20,8'haa,8'h00,8'haa,1'h1,1'h0,8'h00,8'h00,1'h1,1'h1,1'h0,1},
		'{MAD_SWAP,8'h10,8'h00,8'ha5,8'h00,1'h1,1'h0,8'h5a,8'ha5,1'h1,1'h1,1'h0,1},
		'{MAD_NIBBLE_SWAP_IN_PLACE,8'h10,8'h11,8'ha5,8'h00,1'h0,1'h0,8'h11,8'h5a,1'h0,1'h1,1'h0,2},
		'{MAD_RRC,8'h10,8'h00,8'h81,8'h00,1'h0,1'h0,8'h40,8'h81,1'h1,1'h1,1'h0,1},
		'{MAD_RLC,8'h10,8'h00,8'h81,8'h00,1'h1,1'h0,8'h03,8'h81,1'h1,1'h1,1'h0,1},
		'{MAD_ROTATE_RIGHT_CARRY_MEMORY,8'h86,8'h00,8'h02,8'h00,1'h1,1'h0,8'h00,8'h81,1'h0,1'h1,1'h0,1},
		'{MAD_ROTATE_LEFT_CARRY_MEMORY,8'h15,8'h00,8'h80,8'h00,1'h0,1'h0,8'h00,8'h00,1'h1,1'h1,1'h0,2},
		'{MAD_CLR,8'h16,8'h77,8'h99,8'h00,1'h1,1'h0,8'h77,8'h00,1'h1,1'h1,1'h0,1},
		'{MAD_ADD_AM,8'h10,8'h7f,8'h01,8'h00,1'h1,1'h0,8'h80,8'h01,1'h0,1'h0,1'h0,1},
		'{MAD_SUB_AM,8'h10,8'h10,8'h20,8'h00,1'h1,1'h0,8'hf0,8'h20,1'h0,1'h0,1'h0,1},
		'{MAD_SUB_MA,8'h17,8'h30,8'h10,8'h00,1'h0,1'h0,8'h30,8'h20,1'h1,1'h0,1'h0,2},
		'{MAD_SBC_MA,8'h81,8'h10,8'h10,8'h00,1'h0,1'h1,8'h10,8'hff,1'h0,1'h0,1'h0,1},
		'{MAD_AND_AM,8'h10,8'h0f,8'hf0,8'h00,1'h1,1'h0,8'h00,8'hf0,1'h1,1'h1,1'h0,1},
		'{MAD_OR_AM,8'h10,8'h0f,8'h30,8'h00,1'h0,1'h0,8'h3f,8'h30,1'h0,1'h0,1'h0,1},
		'{MAD_OR_MA,8'h18,8'h01,8'h80,8'h00,1'h1,1'h0,8'h01,8'h81,1'h1,1'h0,1'h0,2},
		'{MAD_OR_AI,8'h20,8'ha0,8'h00,8'h05,1'h0,1'h0,8'ha5,8'h00,1'h0,1'h0,1'h0,1},
		'{MAD_XOR_AM,8'h10,8'hff,8'h0f,8'h00,1'h1,1'h0,8'hf0,8'h0f,1'h1,1'h0,1'h0,1},
		'{MAD_XOR_MA,8'h82,8'h55,8'h55,8'h00,1'h0,1'h0,8'h55,8'h00,1'h0,1'h1,1'h0,1}
		};
		@(negedge clk);
		chk(16'({op_ready, op_done, op_illegal, mem_rd, mem_wr}), 16'h0010);
		chk({acc, r_reg}, 16'h0000);
		chk(16'({flag_c, flag_dc, flag_z}), 16'h0000);
		chk(rom_addr, 16'h0000);
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		repeat (3) @(posedge clk);
		foreach (rows[i]) run_row(rows[i]);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk);
			idx_y <= k ? 8'hff : 8'h12;
			idx_z <= k ? 8'hff : 8'h34;
			do_op(MAD_ROM_TABLE_LOOKUP, 8'h00, 8'h00, 1'h0, n, il);
			chk({r_reg, acc}, k ? 16'ha53c : 16'h48f7);
			chk(16'(n), 16'h0002);
			chk(rom_addr, k ? 16'hffff : 16'h1234);
		end
		// Held request: only taken when ready, next one in the done cycle
		do_op(MAD_MOV_AI, 8'h00, 8'h00, 1'h0, n, il);
		@(posedge clk);
		op_code <= MAD_ADD_AI;
		op_imm <= 8'h01;
		op_valid <= 1'h1;
		repeat (9) @(posedge clk);
		op_valid <= 1'h0;
		repeat (10) @(negedge clk);
		chk(16'(acc), 16'h0003);
		// Reset in mid-run, then one instruction to show recovery
		@(posedge clk);
		rst_b <= 1'h0;
		@(negedge clk);
		chk(16'(op_ready), 16'h0001);
		chk({acc, r_reg}, 16'h0000);
		@(posedge clk);
		rst_b <= 1'h1;
		repeat (3) @(posedge clk);
		do_op(MAD_MOV_AI, 8'h00, 8'h5c, 1'h0, n, il);
		chk(16'(acc), 16'h005c);
		print_verdict();
	end
endmodule : mad_datapath_test
`default_nettype wire
